//--- rtl/fb_cfg.svh
// constants for the feedback alarm and home search block
// assumes inclusion by bare name from rtl files
`ifndef FB_CFG_SVH
`define FB_CFG_SVH
`define ADDR_CTRL      12'h000
`define ADDR_LINK      12'h004
`define ADDR_SPACING   12'h008
`define ADDR_STATUS    12'h00C
`define ADDR_IRQ_STAT  12'h010
`define ADDR_IRQ_MASK  12'h014
`define ADDR_POS       12'h018
`define ADDR_DELTA     12'h01C
`define CTRL_START     0
`define CTRL_RESET     32'h0000_0000
`define LINK_RESET     32'h0000_0000
`define FIXED_DEFAULT  16'd1000
`define VAR_DEFAULT    16'd100
`define SPACING_MAX    16'd32000
`define ALARM_BITS_MAX 4'd8
`define DATA_BITS      6'd25
`define IRQ_HOMED      0
`define IRQ_ALARM      1
`define IRQ_FRAME      2
`define IRQ_WIDTH      3
`endif

//--- rtl/fb_pkg.sv
// types for the feedback alarm and home search block
// assumes nothing beyond the compile order
package fb_pkg;
    typedef enum logic [1:0] {SCHEME_SINGLE, SCHEME_INC, SCHEME_DEC, SCHEME_NONE} marker_scheme_type;
    typedef enum logic [1:0] {EDGE_NONE, EDGE_POS, EDGE_NEG, EDGE_RSVD} marker_edge_type;
    typedef enum logic [3:0] {PRESET_UNDEF, PRESET_STD, PRESET_GUSER, PRESET_USER} transmission_preset_type;
    typedef enum {LS_IDLE, LS_WAIT, LS_SHIFT, LS_GAP} link_state_type;
    typedef enum {HS_IDLE, HS_SEEK, HS_SECOND, HS_DONE} home_state_type;
endpackage

//--- rtl/sync_edge.sv
// two-flop synchroniser with edge detection on the synced level
// assumes din is asynchronous to clk
`timescale 1ns/10ps
module sync_edge
    import fb_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // async input and synced outputs
    input  wire logic din,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta;
    logic sync;
    logic last;
    logic next_meta;
    logic next_sync;
    logic next_last;

    // next values of the chain
    always_comb
    begin
        next_meta = din;
        next_sync = meta;
        next_last = sync;
    end

    // register the chain
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            meta <= 1'b0;
            sync <= 1'b0;
            last <= 1'b0;
        end
        else
        begin
            meta <= next_meta;
            sync <= next_sync;
            last <= next_last;
        end
    end

    assign level = sync;
    assign rise  = sync & ~last;
    assign fall  = ~sync & last;
endmodule

//--- rtl/fb_home_alarm.sv
// serial absolute encoder receiver with alarm check and home search
// assumes an APB master on CLK_SYS and encoder pins asynchronous to it
//
// What this block does
// - Alarm bits are shifted in so the first received bit ends up most significant.
// - An encoder error is flagged when the assembled alarm bits equal the match value.
// - A wait of 0 to 255 link clocks follows the first falling edge before the first rising edge.
// - The standard preset fixes link properties, default undefined; the other presets leave them configurable.
// - The single-mark scheme references on the one mark qualified by the home switch.
// - Distance-coded schemes reference after two adjacent marks using their spacing.
// - Increasing and decreasing coding are both accepted; the marker scheme selects the sign of the spacing change.
// - The not-evaluated scheme ignores the reference pulse and homes on the switch if enabled.
// - Edge select none homes when the axis releases the home switch.
// - Edge select positive homes on the rising edge of the reference pulse.
// - Edge select negative homes on the falling edge; none is the default.
// - Fixed mark spacing holds 0 to 32000 periods, default 1000.
// - Variable mark spacing holds 0 to 32000 periods, default 100.
// - The alarm comparison applies only when the alarm bit count is nonzero, 0 to 8.
`timescale 1ns/10ps
`include "fb_cfg.svh"
module fb_home_alarm
    import fb_pkg::*;
(
    // clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RST_B,
    // apb slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // encoder link
    output logic             LINK_CLK,
    input  wire logic        LINK_DATA,
    // home search pins
    input  wire logic        REFERENCE_PULSE,
    input  wire logic        HOME_SWITCH,
    input  wire logic [15:0] MARK_COUNT,
    // interrupt
    output logic             IRQ
);
    logic                    data_lvl;
    logic                    ref_rise;
    logic                    ref_fall;
    logic                    sw_lvl;
    logic                    sw_fall;
    logic                    ref_lvl;
    logic                    sw_rise;
    logic [15:0]             mark_s1;
    logic [15:0]             mark_s2;

    // synchronise pins
    sync_edge u_data (.clk(CLK_SYS), .rst_b(RST_B), .din(LINK_DATA), .level(data_lvl), .rise(), .fall());
    sync_edge u_ref  (.clk(CLK_SYS), .rst_b(RST_B), .din(REFERENCE_PULSE), .level(ref_lvl),
                      .rise(ref_rise), .fall(ref_fall));
    sync_edge u_sw   (.clk(CLK_SYS), .rst_b(RST_B), .din(HOME_SWITCH), .level(sw_lvl),
                      .rise(sw_rise), .fall(sw_fall));

    // register state
    logic [31:0]             ctrl;
    logic [31:0]             link;
    logic [15:0]             fixed_mark_spacing;
    logic [15:0]             variable_mark_spacing;
    logic [`IRQ_WIDTH-1:0]   irq_stat;
    logic [`IRQ_WIDTH-1:0]   irq_mask;
    logic [31:0]             next_ctrl;
    logic [31:0]             next_link;
    logic [15:0]             next_fixed;
    logic [15:0]             next_var;
    logic [`IRQ_WIDTH-1:0]   next_irq_stat;
    logic [`IRQ_WIDTH-1:0]   next_irq_mask;
    logic [31:0]             next_prdata;
    logic [`IRQ_WIDTH-1:0]   events;
    logic                    wr;
    logic                    rd;
    logic                    start_search;

    // configuration fields
    marker_scheme_type       marker_scheme;
    marker_edge_type         marker_edge_select;
    transmission_preset_type transmission_preset;
    logic                    home_switch_use;
    logic [3:0]              alarm_bit_count;
    logic [7:0]              alarm_match_value;
    logic [7:0]              conversion_wait_clocks;
    logic [7:0]              clk_div;
    assign marker_scheme       = marker_scheme_type'(ctrl[2:1]);
    assign marker_edge_select  = marker_edge_type'(ctrl[4:3]);
    assign home_switch_use     = ctrl[5];
    assign transmission_preset = transmission_preset_type'(ctrl[11:8]);
    assign clk_div             = link[31:24];

    // only the standard preset fixes the alarm and wait fields; the other presets take them from link, alarm count capped at 8
    always_comb
    begin
        alarm_bit_count        = (link[3:0] > `ALARM_BITS_MAX) ? `ALARM_BITS_MAX : link[3:0];
        alarm_match_value      = link[15:8];
        conversion_wait_clocks = link[23:16];
        if (transmission_preset == PRESET_STD)
        begin
            alarm_bit_count        = 4'd1;
            alarm_match_value      = 8'h01;
            conversion_wait_clocks = 8'h00;
        end
    end

    assign wr           = PSEL & PENABLE & PWRITE;
    assign rd           = PSEL & PENABLE & ~PWRITE;
    assign start_search = wr & (PADDR == `ADDR_CTRL) & PWDATA[`CTRL_START];
    assign PREADY       = 1'b1;

    // link receiver state
    link_state_type          ls;
    link_state_type          next_ls;
    logic [7:0]              div_cnt;
    logic [7:0]              next_div_cnt;
    logic [8:0]              wait_cnt;
    logic [8:0]              next_wait_cnt;
    logic [5:0]              bit_cnt;
    logic [5:0]              next_bit_cnt;
    logic [7:0]              alarm_sr;
    logic [7:0]              next_alarm_sr;
    logic [31:0]             pos_sr;
    logic [31:0]             next_pos_sr;
    logic [31:0]             position;
    logic [31:0]             next_position;
    logic                    lclk;
    logic                    next_lclk;
    logic                    enc_error;
    logic                    next_enc_error;
    logic                    frame_done;
    logic                    tick;
    logic [5:0]              frame_bits;

    assign tick       = (div_cnt >= clk_div); // a smaller divider never strands the count
    assign frame_bits = 6'(alarm_bit_count) + `DATA_BITS;

    // next state of the link receiver; alarm bits come first in the frame
    always_comb
    begin
        next_ls        = ls;
        next_div_cnt   = tick ? 8'h00 : 8'(div_cnt + 8'h01);
        next_wait_cnt  = wait_cnt;
        next_bit_cnt   = bit_cnt;
        next_alarm_sr  = alarm_sr;
        next_pos_sr    = pos_sr;
        next_position  = position;
        next_lclk      = lclk;
        next_enc_error = enc_error;
        frame_done     = 1'b0;
        case (ls)
            LS_IDLE:
            begin
                if (tick)
                begin
                    next_lclk     = 1'b0; // first falling edge
                    next_wait_cnt = {conversion_wait_clocks, 1'b0}; // two half periods per wait clock
                    next_bit_cnt  = 6'h00;
                    next_alarm_sr = 8'h00;
                    next_pos_sr   = 32'h0000_0000;
                    next_ls       = LS_WAIT;
                end
            end
            LS_WAIT:
            begin
                next_lclk = 1'b0; // no rising edge until the wait is over
                if (tick)
                begin
                    if (wait_cnt == 9'h000)
                    begin
                        next_lclk = 1'b1;
                        next_ls   = LS_SHIFT;
                    end
                    else
                        next_wait_cnt = 9'(wait_cnt - 9'h001);
                end
            end
            LS_SHIFT:
            begin
                if (tick)
                begin
                    next_lclk = ~lclk;
                    if (!lclk)
                    begin
                        // sample on the rising edge
                        if (bit_cnt < 6'(alarm_bit_count))
                            next_alarm_sr = {alarm_sr[6:0], data_lvl};
                        else
                            next_pos_sr = {pos_sr[30:0], data_lvl};
                        next_bit_cnt = 6'(bit_cnt + 6'h01);
                        if (6'(bit_cnt + 6'h01) == frame_bits)
                            next_ls = LS_GAP;
                    end
                end
            end
            LS_GAP:
            begin
                next_lclk = 1'b1;
                if (tick)
                begin
                    frame_done     = 1'b1;
                    next_position  = pos_sr;
                    next_enc_error = (alarm_bit_count != 4'd0) && (alarm_sr == alarm_match_value);
                    next_ls        = LS_IDLE;
                end
            end
            default:
                next_ls = LS_IDLE;
        endcase
    end

    // register the link receiver
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_B)
        begin
            ls        <= LS_IDLE;
            div_cnt   <= 8'h00;
            wait_cnt  <= 9'h000;
            bit_cnt   <= 6'h00;
            alarm_sr  <= 8'h00;
            pos_sr    <= 32'h0000_0000;
            position  <= 32'h0000_0000;
            lclk      <= 1'b1;
            enc_error <= 1'b0;
        end
        else
        begin
            ls        <= next_ls;
            div_cnt   <= next_div_cnt;
            wait_cnt  <= next_wait_cnt;
            bit_cnt   <= next_bit_cnt;
            alarm_sr  <= next_alarm_sr;
            pos_sr    <= next_pos_sr;
            position  <= next_position;
            lclk      <= next_lclk;
            enc_error <= next_enc_error;
        end
    end
    assign LINK_CLK = lclk;

    // home search state
    home_state_type          hs;
    home_state_type          next_hs;
    logic                    homed;
    logic                    next_homed;
    logic [15:0]             first_mark;
    logic [15:0]             next_first_mark;
    logic [15:0]             mark_delta;
    logic [15:0]             next_mark_delta;
    logic                    marker_hit;
    logic                    alarm_evt;

    // marker edge as selected; scheme none ignores the pulse
    always_comb
    begin
        case (marker_edge_select)
            EDGE_POS: marker_hit = ref_rise;
            EDGE_NEG: marker_hit = ref_fall;
            default:  marker_hit = 1'b0;
        endcase
    end
    assign alarm_evt = frame_done & next_enc_error;

    // next state of the search
    always_comb
    begin
        next_hs         = hs;
        next_homed      = homed;
        next_first_mark = first_mark;
        next_mark_delta = mark_delta;
        case (hs)
            HS_IDLE:
                ;
            HS_SEEK:
            begin
                if (marker_scheme == SCHEME_NONE)
                begin
                    if (home_switch_use && sw_fall)
                        next_hs = HS_DONE;
                end
                else if (marker_edge_select == EDGE_NONE)
                begin
                    if (sw_fall)
                        next_hs = HS_DONE;
                end
                else if (marker_hit)
                begin
                    if (marker_scheme == SCHEME_SINGLE)
                    begin
                        if (!home_switch_use || sw_lvl)
                            next_hs = HS_DONE;
                    end
                    else
                    begin
                        next_first_mark = mark_s2;
                        next_hs         = HS_SECOND;
                    end
                end
            end
            HS_SECOND:
            begin
                if (marker_hit && marker_scheme != SCHEME_NONE)
                begin
                    // marker scheme gives the coding direction of the signed spacing change
                    if (marker_scheme == SCHEME_INC)
                        next_mark_delta = 16'(mark_s2 - first_mark - fixed_mark_spacing);
                    else
                        next_mark_delta = 16'(fixed_mark_spacing - (mark_s2 - first_mark));
                    next_hs = HS_DONE;
                end
            end
            HS_DONE:
                next_homed = 1'b1;
            default:
                next_hs = HS_IDLE;
        endcase
        if (alarm_evt)
        begin
            next_homed = 1'b0;
            next_hs    = HS_IDLE;
        end
        if (start_search)
        begin
            next_homed      = 1'b0;
            next_mark_delta = 16'h0000;
            next_hs         = HS_SEEK;
        end
    end

    // register the search and sample the mark counter
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_B)
        begin
            hs         <= HS_IDLE;
            homed      <= 1'b0;
            first_mark <= 16'h0000;
            mark_delta <= 16'h0000;
            mark_s1    <= 16'h0000;
            mark_s2    <= 16'h0000;
        end
        else
        begin
            hs         <= next_hs;
            homed      <= next_homed;
            first_mark <= next_first_mark;
            mark_delta <= next_mark_delta;
            mark_s1    <= MARK_COUNT;
            mark_s2    <= mark_s1;
        end
    end

    // register writes, sticky events with set over read clear
    always_comb
    begin
        next_ctrl     = ctrl;
        next_link     = link;
        next_fixed    = fixed_mark_spacing;
        next_var      = variable_mark_spacing;
        next_irq_mask = irq_mask;
        next_irq_stat = irq_stat;
        events        = '0;
        events[`IRQ_HOMED] = next_homed & ~homed;
        events[`IRQ_ALARM] = alarm_evt;
        events[`IRQ_FRAME] = frame_done;
        if (wr)
        begin
            case (PADDR)
                `ADDR_CTRL:     next_ctrl     = {PWDATA[31:1], 1'b0};
                `ADDR_LINK:     next_link     = PWDATA;
                `ADDR_SPACING:
                begin
                    next_fixed = (PWDATA[15:0] > `SPACING_MAX) ? `SPACING_MAX : PWDATA[15:0];
                    next_var   = (PWDATA[31:16] > `SPACING_MAX) ? `SPACING_MAX : PWDATA[31:16];
                end
                `ADDR_IRQ_MASK: next_irq_mask = PWDATA[`IRQ_WIDTH-1:0];
                default:        ;
            endcase
        end
        if (rd && PADDR == `ADDR_IRQ_STAT)
            next_irq_stat = irq_stat & ~PRDATA[`IRQ_WIDTH-1:0]; // clear only what the read returned
        next_irq_stat = next_irq_stat | events;
    end

    // read mux
    always_comb
    begin
        case (PADDR)
            `ADDR_CTRL:     next_prdata = ctrl;
            `ADDR_LINK:     next_prdata = link;
            `ADDR_SPACING:  next_prdata = {variable_mark_spacing, fixed_mark_spacing};
            `ADDR_STATUS:   next_prdata = {26'h0, sw_lvl, ref_lvl, enc_error, homed, (hs != HS_IDLE), 1'b0};
            `ADDR_IRQ_STAT: next_prdata = {29'h0, irq_stat};
            `ADDR_IRQ_MASK: next_prdata = {29'h0, irq_mask};
            `ADDR_POS:      next_prdata = position;
            `ADDR_DELTA:    next_prdata = {16'h0, mark_delta};
            default:        next_prdata = 32'h0000_0000;
        endcase
    end

    // register file
    always_ff @(posedge CLK_SYS)
    begin
        if (!RST_B)
        begin
            ctrl                  <= `CTRL_RESET;
            link                  <= `LINK_RESET;
            fixed_mark_spacing    <= `FIXED_DEFAULT;
            variable_mark_spacing <= `VAR_DEFAULT;
            irq_stat              <= '0;
            irq_mask              <= '0;
            PRDATA                <= 32'h0000_0000;
            IRQ                   <= 1'b0;
        end
        else
        begin
            ctrl                  <= next_ctrl;
            link                  <= next_link;
            fixed_mark_spacing    <= next_fixed;
            variable_mark_spacing <= next_var;
            irq_stat              <= next_irq_stat;
            irq_mask              <= next_irq_mask;
            PRDATA                <= (PSEL & ~PENABLE & ~PWRITE) ? next_prdata : PRDATA;
            IRQ                   <= |(next_irq_stat & next_irq_mask);
        end
    end
    assign PSLVERR = 1'b0;

    // error flag follows the alarm match at frame end
    a_alarm_match: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        frame_done |=> enc_error == (($past(alarm_bit_count) != 4'd0)
                                     && ($past(alarm_sr) == $past(alarm_match_value))))
        else $error("alarm match wrong");
    // no error without alarm bits
    a_alarm_zero: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        (frame_done && alarm_bit_count == 4'd0) |=> !enc_error)
        else $error("alarm without bits");
    // homed clears on new search
    a_search_clear: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        start_search |=> !homed && hs == HS_SEEK)
        else $error("search did not clear");
    // homed holds
    a_homed_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        (homed && !start_search && !alarm_evt) |=> homed)
        else $error("homed dropped");
    // scheme none never homes on a marker without switch
    a_scheme_none: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        (hs == HS_SEEK && marker_scheme == SCHEME_NONE && !sw_fall && !start_search) |=> hs != HS_DONE)
        else $error("scheme none homed");
    // edge none homes on switch release
    a_edge_none: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        (hs == HS_SEEK && marker_scheme != SCHEME_NONE && marker_edge_select == EDGE_NONE && sw_fall
         && !start_search && !alarm_evt) |=> hs == HS_DONE ##1 homed)
        else $error("switch release not homed");
    // positive edge homing in single scheme
    a_edge_pos: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        (hs == HS_SEEK && marker_scheme == SCHEME_SINGLE && marker_edge_select == EDGE_POS && ref_rise
         && (!home_switch_use || sw_lvl) && !start_search && !alarm_evt) |=> hs == HS_DONE)
        else $error("rising marker missed");
    // negative edge never homes on rise alone; an alarm may still end the search
    a_edge_neg: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        (hs == HS_SEEK && marker_scheme == SCHEME_SINGLE && marker_edge_select == EDGE_NEG && !ref_fall
         && !start_search && !alarm_evt) |=> hs == HS_SEEK)
        else $error("negative edge misfire");
    // spacing stays in range
    a_spacing_range: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        fixed_mark_spacing <= `SPACING_MAX && variable_mark_spacing <= `SPACING_MAX)
        else $error("spacing out of range");
    // first fall opens the frame
    a_wait_high: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        (ls == LS_IDLE && tick) |=> !lclk)
        else $error("first fall missing");
    // link clock stays low for the whole conversion wait
    a_wait_low: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        ls == LS_WAIT |-> !lclk)
        else $error("rise during wait");
endmodule

//--- bench/enc_model.sv
// encoder model: sends one frame, first bit first, on link clock falls
// assumes the link clock idles high between frames, half period 30 ns
`timescale 1ns/10ps
module enc_model
(
    // link pins
    input  wire logic        link_clk,
    output logic             link_data,
    // alarm bits above 25 data bits, and the bit count
    input  wire logic [32:0] frame,
    input  wire logic [5:0]  frame_len
);
    int      idx;
    realtime last_rise;
    // a fall after a long high restarts the bit index; each later fall puts out the next bit
    always @(negedge link_clk)
    begin
        if ($realtime - last_rise > 45.0)
            idx = 0;
        else
        begin
            link_data = (idx < frame_len) ? frame[frame_len - 1 - idx] : ~link_data;
            idx++;
        end
    end
    // time of the last rise, for idle detection
    always @(posedge link_clk)
        last_rise = $realtime;
    initial
        link_data = 1'b1;
endmodule

//--- bench/fb_home_alarm_bench.sv
// bench for the alarm check and home search block
// assumes zero wait state apb and enc_model on the link
`timescale 1ns/10ps
`include "fb_cfg.svh"
module fb_home_alarm_bench;
    logic        clk, rst_b, psel, pen, pwr, pready, lclk, ldata, refp, hsw, irq, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r, acc;
    logic [15:0] mark;
    logic [32:0] frame;
    logic [5:0]  flen;
    int          miscompares, tests_run;
    int          ac[5] = '{2, 2, 1, 1, 0};
    int          ap[5] = '{2, 1, 0, 1, 0};
    logic [31:0] hc[4] = '{32'h09, 32'h11, 32'h2F, 32'h21};
    logic        h1[4] = '{1, 0, 0, 0};
    logic        h2[4] = '{1, 1, 0, 0};
    fb_home_alarm DUT (.CLK_SYS(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(), .LINK_CLK(lclk), .LINK_DATA(ldata),
        .REFERENCE_PULSE(refp), .HOME_SWITCH(hsw), .MARK_COUNT(mark), .IRQ(irq));
    enc_model encoder (.link_clk(lclk), .link_data(ldata), .frame(frame), .frame_len(flen));
    // 200 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // one transfer, held until pready is seen high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(r & m, exp);
    endtask
    // polls until a frame ends, gathering the sticky bits seen
    task frm();
        acc = 32'h0;
        do
        begin
            apb(1'b0, `ADDR_IRQ_STAT, 32'h0);
            acc |= r;
        end
        while (r[`IRQ_FRAME] !== 1'b1);
    endtask
    task pins(input logic rp, input logic hs);
        refp <= rp;
        hsw <= hs;
        repeat (10) @(posedge clk);
    endtask
    task finish_test();
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // watchdog
    initial
    begin
        repeat (80000) @(posedge clk);
        miscompares++;
        finish_test();
    end
    // main sequence
    initial
    begin
        {rst_b, psel, pen, pwr, refp, hsw} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        mark = 16'h0;
        frame = 33'h0;
        flen = 6'd25;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        rd(`ADDR_SPACING, '1, 32'h0064_03E8);
        rd(`ADDR_CTRL, '1, 32'h0);
        rd(`ADDR_LINK, '1, 32'h0);
        rd(12'h020, '1, 32'h0);
        apb(1'b1, `ADDR_IRQ_MASK, 32'h2);
        // alarm width and pattern table, match equal to the width
        for (int i = 0; i < 5; i++)
        begin
            e = (ac[i] != 0 && ap[i] == ac[i]);
            frame <= (33'(ap[i]) << 25) | 33'h0ABCDEF;
            flen <= 6'(25 + ac[i]);
            apb(1'b1, `ADDR_LINK, {8'h05, 8'(i), 8'(ac[i]), 4'h0, 4'(ac[i])});
            frm();
            frm();
            frm();
            chk(acc & 32'h2, {30'h0, e, 1'b0});
            rd(`ADDR_STATUS, 32'h8, {28'h0, e, 3'h0});
            rd(`ADDR_POS, 32'h1FF_FFFF, 32'h0ABCDEF);
            for (int k = 0; k < 2000 && irq !== 1'b1; k++)
                @(posedge clk);
            chk({31'h0, irq}, {31'h0, e});
            if (e)
            begin
                apb(1'b1, `ADDR_IRQ_MASK, 32'h0);
                repeat (2) @(posedge clk);
                chk({31'h0, irq}, 32'h0);
                apb(1'b1, `ADDR_IRQ_MASK, 32'h2);
            end
        end
        // standard preset forces one alarm bit matched against 1 and no wait
        apb(1'b1, `ADDR_CTRL, 32'h100);
        frame <= (33'h1 << 25) | 33'h0ABCDEF;
        flen <= 6'd26;
        apb(1'b1, `ADDR_LINK, 32'h0503_0000);
        frm();
        frm();
        frm();
        chk(acc & 32'h2, 32'h2);
        rd(`ADDR_POS, 32'h1FF_FFFF, 32'h0ABCDEF);
        // single and unevaluated schemes over the edge choices
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, `ADDR_CTRL, hc[i]);
            pins(1'b1, 1'b1);
            rd(`ADDR_STATUS, 32'h4, {29'h0, h1[i], 2'h0});
            pins(1'b0, 1'b1);
            rd(`ADDR_STATUS, 32'h4, {29'h0, h2[i], 2'h0});
            pins(1'b0, 1'b0);
            rd(`ADDR_STATUS, 32'h4, 32'h4);
        end
        apb(1'b1, `ADDR_SPACING, {16'(20020 / 20), 16'(20000 / 20)});
        // increasing then decreasing coding, both one period off the fixed spacing
        for (int i = 0; i < 2; i++)
        begin
            apb(1'b1, `ADDR_CTRL, i ? 32'h0D : 32'h0B);
            mark <= 16'd100;
            pins(1'b1, 1'b0);
            pins(1'b0, 1'b0);
            rd(`ADDR_STATUS, 32'h4, 32'h0);
            mark <= i ? 16'd1099 : 16'd1101;
            pins(1'b1, 1'b0);
            pins(1'b0, 1'b0);
            rd(`ADDR_STATUS, 32'h4, 32'h4);
            rd(`ADDR_DELTA, '1, 32'h1);
        end
        finish_test();
    end
endmodule
